/* File: axil_reg_slave.sv */
// axi4-lite slave turning bus transfers into register strobes
// assumes register file answers hit and read data combinationally
`default_nettype none
`include "ring_val_defines.svh"
module axil_reg_slave #(
   parameter int ADDR_W = 8
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [ADDR_W-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   reg_bus_if.slave bus
);
   logic aw_full_r;
   logic w_full_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_be_r;
   logic do_wr;
   logic aw_take;
   logic w_take;
   logic ar_take;

   // channel acceptance, write fires once both halves are held
   assign s_awready = !aw_full_r && !s_bvalid;
   assign s_wready = !w_full_r && !s_bvalid;
   assign s_arready = !s_rvalid;
   assign aw_take = s_awvalid && s_awready;
   assign w_take = s_wvalid && s_wready;
   assign ar_take = s_arvalid && s_arready;
   assign do_wr = aw_full_r && w_full_r && !s_bvalid;
   assign bus.wr_stb = do_wr;
   assign bus.wr_be = w_be_r;
   assign bus.wr_addr = aw_addr_r;
   assign bus.wr_data = w_data_r;
   assign bus.rd_addr = s_araddr;

   // write side holding and response
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 8'h00;
         w_be_r <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp <= `RV_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_awaddr;
         end
         if (w_take) begin
            w_full_r <= 1'b1;
            w_data_r <= s_wdata[7:0];
            w_be_r <= s_wstrb[0];
         end
         if (do_wr) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= bus.wr_hit ? `RV_RESP_OKAY : `RV_RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // read answer one cycle after address
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= `RV_RESP_OKAY;
      end else if (ar_take) begin
         s_rvalid <= 1'b1;
         s_rdata <= {24'h00_0000, bus.rd_data};
         s_rresp <= bus.rd_hit ? `RV_RESP_OKAY : `RV_RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end

   property p_write_answer;
      @(posedge sys_clk) disable iff (!arst_n) do_wr |=> s_bvalid && !s_awready;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("no write response");
   property p_read_hold;
      @(posedge sys_clk) disable iff (!arst_n)
         s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("read data dropped");
   c_write: cover property (@(posedge sys_clk) disable iff (!arst_n) do_wr);
endmodule : axil_reg_slave
`default_nettype wire

/* File: reg_bus_if.sv */
// register access carrier between bus slave and register file
// assumes one clock; strobes are one-cycle pulses
`default_nettype none
interface reg_bus_if #(parameter int ADDR_W = 8);
   logic wr_stb;
   logic wr_be;
   logic [ADDR_W-1:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_hit;
   logic [ADDR_W-1:0] rd_addr;
   logic [7:0] rd_data;
   logic rd_hit;
   modport slave (output wr_stb, wr_be, wr_addr, wr_data, rd_addr,
      input wr_hit, rd_data, rd_hit);
   modport regs (input wr_stb, wr_be, wr_addr, wr_data, rd_addr,
      output wr_hit, rd_data, rd_hit);
endinterface : reg_bus_if
`default_nettype wire

/* File: ring_line_model.sv */
// line model: square wave on the ring detector output, one rising crossing per period
// assumes sys_clk from the bench; a half period of zero holds the line quiet
`default_nettype none
module ring_line_model (
   input wire logic sys_clk,
   input wire logic [7:0] half,
   output logic ring_cross
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_r = 8'h00;
   logic lvl_r = 1'b0;
   // single driver for the detector output
   assign ring_cross = lvl_r;
   // toggle each half period, half cycles per level; low while quiet
   always @(posedge sys_clk) begin
      if (half == 8'h00) begin
         lvl_r <= 1'b0;
         cnt_r <= 8'h00;
      end else if (cnt_r >= half - 8'h01) begin
         lvl_r <= ~lvl_r;
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule : ring_line_model
`default_nettype wire

/* File: ring_val_defines.svh */
// ring validation constants: register indices, byte addresses, fields, resets, timing
// assumes inclusion by bare name from every design file that needs them
`ifndef RING_VAL_DEFINES_SVH
`define RING_VAL_DEFINES_SVH

// register indices and aligned byte addresses (index times four)
`define RV_IDX_SPACING 8'h16
`define RV_IDX_CTRL2 8'h17
`define RV_IDX_CTRL3 8'h18
`define RV_IDX_IRQ_STAT 8'h19
`define RV_IDX_IRQ_CLR 8'h1a
`define RV_IDX_IRQ_EN 8'h1b
`define RV_IDX_LINE_STAT 8'h1c
`define RV_ADDR_SPACING (8'(`RV_IDX_SPACING * 4))
`define RV_ADDR_CTRL2 (8'(`RV_IDX_CTRL2 * 4))
`define RV_ADDR_CTRL3 (8'(`RV_IDX_CTRL3 * 4))
`define RV_ADDR_IRQ_STAT (8'(`RV_IDX_IRQ_STAT * 4))
`define RV_ADDR_IRQ_CLR (8'(`RV_IDX_IRQ_CLR * 4))
`define RV_ADDR_IRQ_EN (8'(`RV_IDX_IRQ_EN * 4))
`define RV_ADDR_LINE_STAT (8'(`RV_IDX_LINE_STAT * 4))

// reset values
`define RV_RST_CTRL2 8'h2d
`define RV_RST_CTRL3 8'h19
`define RV_RST_SPACING 8'h00

// field positions
`define RV_DLY_HI_BIT 7
`define RV_TO_MSB 6
`define RV_TO_LSB 3
`define RV_CC_MSB 2
`define RV_CC_LSB 0
`define RV_EN_BIT 7
`define RV_AS_MSB 5
`define RV_SP_MSB 5
`define RV_DLY_LO_MSB 7
`define RV_DLY_LO_LSB 6

// interrupt status bits
`define RV_IRQ_VALID 0
`define RV_IRQ_END 1
`define RV_IRQ_HIGH 2

// timing: clock rate, step and millisecond tick
`define RV_CLK_KHZ 40000
`define RV_STEP_US 2000
`define RV_MS_US 1000
`define RV_STEP_CYCLES (`RV_STEP_US * `RV_CLK_KHZ / 1000)
`define RV_MS_CYCLES (`RV_MS_US * `RV_CLK_KHZ / 1000)

// confirmation times in ms per code
`define RV_CC0_MS 11'd100
`define RV_CC1_MS 11'd150
`define RV_CC2_MS 11'd200
`define RV_CC3_MS 11'd256
`define RV_CC4_MS 11'd384
`define RV_CC5_MS 11'd512
`define RV_CC6_MS 11'd640
`define RV_CC7_MS 11'd1024
// timeout: shortest code, then code times unit
`define RV_TO0_MS 11'd80
`define RV_TO_UNIT_LSB 7
`define RV_DLY_UNIT_LSB 8

// bus responses
`define RV_RESP_OKAY 2'b00
`define RV_RESP_SLVERR 2'b10

`endif

/* File: ring_val_pkg.sv */
// types shared by the ring validation design
// assumes no other package
`default_nettype none
package ring_val_pkg;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_CONFIRM = 2'b01,
      S_DELAY = 2'b10,
      S_VALID = 2'b11
   } ring_state_t;
endpackage : ring_val_pkg
`default_nettype wire

/* File: ring_validation_timing.sv */
// ring validation timing: qualifies ringing from threshold-crossing events
// assumes ring_cross is an asynchronous pin, software on axi4-lite, 40 MHz sys_clk
// Overview of operation
// R1 - each rising crossing of the synchronised detector is one event
// R2 - every event loads the six-bit assertion time into a down-counting timer
// R3 - next event with timer above minimum spacing invalidates the ring
// R4 - the qualification timer steps once every 2.0 ms
// R5 - assertion time sets the highest accepted ring frequency, ten percent tolerance
// R6 - software keeps minimum spacing at most the assertion time, plus one margin
// R7 - ring valid only after frequency stays good for the confirmation time
// R8 - valid ring indicated after the selected delay, zero to 1792 ms
// R9 - ring ends when the timeout passes with no crossing
// R10 - validation runs only while the enable bit is set, in any power mode
// R11 - reserved bit six of control three carries no meaning on read
// R12 - the qualification timer holds at zero instead of wrapping
`default_nettype none
`include "ring_val_defines.svh"
module ring_validation_timing #(
   parameter int STEP_CYCLES = `RV_STEP_CYCLES,
   parameter int MS_CYCLES = `RV_MS_CYCLES,
   parameter int ADDR_W = 8
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [ADDR_W-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic ring_cross,
   output logic ring_valid,
   output logic irq
);
   if (ADDR_W != 8) begin : g_bad_addr
      $error("ring_validation_timing: ADDR_W must be 8");
   end

   reg_bus_if #(.ADDR_W(ADDR_W)) bus ();
   logic step_tick;
   logic ms_tick;

   axil_reg_slave #(.ADDR_W(ADDR_W)) u_slave (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .bus(bus.slave)
   );

   step_tick_gen #(.CYCLES(STEP_CYCLES)) u_step (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .tick(step_tick)
   );

   step_tick_gen #(.CYCLES(MS_CYCLES)) u_ms (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .tick(ms_tick)
   );

   // software registers
   logic [7:0] ctrl2_r;
   logic [7:0] spacing_r;
   logic [5:0] assert_r;
   logic enable_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_en_r;
   logic [2:0] irq_stat_nxt;
   logic [2:0] clr_bits;
   // line side and sequencing state
   logic sync1_r;
   logic sync2_r;
   logic sync3_r;
   logic line_evt;
   logic [5:0] qual_r;
   logic [5:0] qual_nxt;
   logic [10:0] to_r;
   logic [10:0] to_nxt;
   logic [10:0] ph_r;
   logic [10:0] ph_nxt;
   ring_val_pkg::ring_state_t st_r;
   ring_val_pkg::ring_state_t st_nxt;
   logic phase_clr;
   logic ring_valid_nxt;

   // register write decode
   logic wr_ok;
   logic wr_spacing;
   logic wr_ctrl2;
   logic wr_ctrl3;
   logic wr_clr;
   logic wr_en;
   assign wr_ok = bus.wr_stb && bus.wr_be;
   assign wr_spacing = wr_ok && (bus.wr_addr == `RV_ADDR_SPACING);
   assign wr_ctrl2 = wr_ok && (bus.wr_addr == `RV_ADDR_CTRL2);
   assign wr_ctrl3 = wr_ok && (bus.wr_addr == `RV_ADDR_CTRL3);
   assign wr_clr = wr_ok && (bus.wr_addr == `RV_ADDR_IRQ_CLR);
   assign wr_en = wr_ok && (bus.wr_addr == `RV_ADDR_IRQ_EN);
   assign bus.wr_hit = (bus.wr_addr == `RV_ADDR_SPACING) || (bus.wr_addr == `RV_ADDR_CTRL2)
      || (bus.wr_addr == `RV_ADDR_CTRL3) || (bus.wr_addr == `RV_ADDR_IRQ_STAT)
      || (bus.wr_addr == `RV_ADDR_IRQ_CLR) || (bus.wr_addr == `RV_ADDR_IRQ_EN)
      || (bus.wr_addr == `RV_ADDR_LINE_STAT);

   // read mux; clear register reads zero
   logic [7:0] ctrl3_view;
   logic [7:0] line_view;
   assign ctrl3_view = {enable_r, 1'b0, assert_r}; // R11
   assign line_view = {5'h00, ring_valid, st_r};
   assign bus.rd_data = (bus.rd_addr == `RV_ADDR_SPACING) ? spacing_r :
      (bus.rd_addr == `RV_ADDR_CTRL2) ? ctrl2_r :
      (bus.rd_addr == `RV_ADDR_CTRL3) ? ctrl3_view :
      (bus.rd_addr == `RV_ADDR_IRQ_STAT) ? {5'h00, irq_stat_r} :
      (bus.rd_addr == `RV_ADDR_IRQ_EN) ? {5'h00, irq_en_r} :
      (bus.rd_addr == `RV_ADDR_LINE_STAT) ? line_view : 8'h00;
   assign bus.rd_hit = (bus.rd_addr == `RV_ADDR_SPACING) || (bus.rd_addr == `RV_ADDR_CTRL2)
      || (bus.rd_addr == `RV_ADDR_CTRL3) || (bus.rd_addr == `RV_ADDR_IRQ_STAT)
      || (bus.rd_addr == `RV_ADDR_IRQ_CLR) || (bus.rd_addr == `RV_ADDR_IRQ_EN)
      || (bus.rd_addr == `RV_ADDR_LINE_STAT);

   // field views
   logic [5:0] min_sp;
   logic [2:0] dly_code;
   logic [3:0] to_code;
   logic [10:0] confirm_ms;
   logic [10:0] delay_ms;
   logic [10:0] timeout_ms;
   assign min_sp = spacing_r[`RV_SP_MSB:0];
   assign dly_code = {ctrl2_r[`RV_DLY_HI_BIT], spacing_r[`RV_DLY_LO_MSB:`RV_DLY_LO_LSB]};
   assign to_code = ctrl2_r[`RV_TO_MSB:`RV_TO_LSB];

   // confirmation code to milliseconds
   function automatic logic [10:0] cc_ms(input logic [2:0] code);
      case (code)
         3'h0: cc_ms = `RV_CC0_MS;
         3'h1: cc_ms = `RV_CC1_MS;
         3'h2: cc_ms = `RV_CC2_MS;
         3'h3: cc_ms = `RV_CC3_MS;
         3'h4: cc_ms = `RV_CC4_MS;
         3'h5: cc_ms = `RV_CC5_MS;
         3'h6: cc_ms = `RV_CC6_MS;
         default: cc_ms = `RV_CC7_MS;
      endcase
   endfunction : cc_ms

   assign confirm_ms = cc_ms(ctrl2_r[`RV_CC_MSB:`RV_CC_LSB]); // R7
   assign delay_ms = {dly_code, 8'h00}; // R8
   assign timeout_ms = (to_code == 4'h0) ? `RV_TO0_MS : {to_code, 7'h00}; // R9

   // line event from synchronised detector
   assign line_evt = sync2_r && !sync3_r; // R1

   // timer reload, 2 ms countdown, stop at zero
   assign qual_nxt = line_evt ? assert_r : // R2
      (step_tick && qual_r != 6'h00) ? qual_r - 6'h01 : qual_r; // R4 R12

   // frequency check and silence timeout
   logic too_high;
   logic timed_out;
   assign too_high = enable_r && line_evt && st_r != ring_val_pkg::S_IDLE
      && qual_r > min_sp; // R3 R5 R6
   assign timed_out = enable_r && st_r != ring_val_pkg::S_IDLE && to_r >= timeout_ms; // R9
   assign to_nxt = line_evt ? 11'h000 : (ms_tick && to_r != 11'h7ff) ? to_r + 11'h001 : to_r;
   assign ph_nxt = phase_clr ? 11'h000 : (ms_tick && ph_r != 11'h7ff) ? ph_r + 11'h001 : ph_r;

   // qualification sequence
   always_comb begin
      st_nxt = st_r;
      phase_clr = 1'b0;
      case (st_r)
         ring_val_pkg::S_IDLE: begin
            phase_clr = 1'b1;
            if (line_evt) begin
               st_nxt = ring_val_pkg::S_CONFIRM;
            end
         end
         ring_val_pkg::S_CONFIRM: begin
            if (ph_r >= confirm_ms) begin // R7
               st_nxt = (delay_ms == 11'h000) ? ring_val_pkg::S_VALID : ring_val_pkg::S_DELAY;
               phase_clr = 1'b1;
            end
         end
         ring_val_pkg::S_DELAY: begin
            if (ph_r >= delay_ms) begin // R8
               st_nxt = ring_val_pkg::S_VALID;
            end
         end
         ring_val_pkg::S_VALID: begin
            st_nxt = ring_val_pkg::S_VALID;
         end
         default: begin
            st_nxt = ring_val_pkg::S_IDLE;
         end
      endcase
      if (!enable_r || too_high || timed_out) begin // R10 R3 R9
         st_nxt = ring_val_pkg::S_IDLE;
         phase_clr = 1'b1;
      end
   end

   // sticky status, set wins over clear
   assign ring_valid_nxt = (st_nxt == ring_val_pkg::S_VALID);
   assign clr_bits = wr_clr ? bus.wr_data[2:0] : 3'h0;
   assign irq_stat_nxt = (irq_stat_r & ~clr_bits)
      | {too_high, timed_out, ring_valid_nxt && !ring_valid};
   assign irq = |(irq_stat_r & irq_en_r);

   // pin synchroniser
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else begin
         sync1_r <= ring_cross;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // software registers
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl2_r <= `RV_RST_CTRL2;
         spacing_r <= `RV_RST_SPACING;
         assert_r <= 6'(`RV_RST_CTRL3);
         enable_r <= 1'(`RV_RST_CTRL3 >> `RV_EN_BIT);
         irq_en_r <= 3'h0;
      end else begin
         if (wr_ctrl2) ctrl2_r <= bus.wr_data;
         if (wr_spacing) spacing_r <= bus.wr_data;
         if (wr_ctrl3) assert_r <= bus.wr_data[`RV_AS_MSB:0];
         if (wr_ctrl3) enable_r <= bus.wr_data[`RV_EN_BIT]; // R10
         if (wr_en) irq_en_r <= bus.wr_data[2:0];
      end
   end

   // sequencing state
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         qual_r <= 6'h00;
         to_r <= 11'h000;
         ph_r <= 11'h000;
         st_r <= ring_val_pkg::S_IDLE;
         ring_valid <= 1'b0;
         irq_stat_r <= 3'h0;
      end else begin
         qual_r <= qual_nxt;
         to_r <= to_nxt;
         ph_r <= ph_nxt;
         st_r <= st_nxt;
         ring_valid <= ring_valid_nxt;
         irq_stat_r <= irq_stat_nxt;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   property p_evt_edge;
      line_evt |-> $past(sync2_r) == 1'b0 && !$past(line_evt);
   endproperty
   a_evt_edge: assert property (p_evt_edge) else $error("event not on rise"); // R1
   property p_reload;
      line_evt |=> qual_r == $past(assert_r);
   endproperty
   a_reload: assert property (p_reload) else $error("timer not reloaded"); // R2
   property p_step;
      step_tick && !line_evt && qual_r != 6'h00 |=> qual_r == $past(qual_r) - 6'h01;
   endproperty
   a_step: assert property (p_step) else $error("timer did not step"); // R4
   property p_hold_zero;
      qual_r == 6'h00 && !line_evt |=> qual_r == 6'h00;
   endproperty
   a_hold_zero: assert property (p_hold_zero) else $error("timer wrapped"); // R12
   property p_too_high;
      enable_r && line_evt && st_r != ring_val_pkg::S_IDLE && qual_r > min_sp
         |=> st_r == ring_val_pkg::S_IDLE && irq_stat_r[`RV_IRQ_HIGH];
   endproperty
   a_too_high: assert property (p_too_high) else $error("fast ring kept"); // R3
   property p_confirm;
      st_r == ring_val_pkg::S_CONFIRM ##1 st_r != ring_val_pkg::S_CONFIRM
         && st_r != ring_val_pkg::S_IDLE |-> $past(ph_r) >= $past(confirm_ms);
   endproperty
   a_confirm: assert property (p_confirm) else $error("confirmed early"); // R7
   property p_valid_rise;
      $rose(ring_valid) |-> $past(st_r) != ring_val_pkg::S_IDLE
         && (($past(st_r) == ring_val_pkg::S_DELAY && $past(ph_r) >= $past(delay_ms))
         || ($past(st_r) == ring_val_pkg::S_CONFIRM && $past(delay_ms) == 11'h000));
   endproperty
   a_valid_rise: assert property (p_valid_rise) else $error("valid without delay"); // R8
   property p_timeout;
      timed_out |=> !ring_valid && irq_stat_r[`RV_IRQ_END];
   endproperty
   a_timeout: assert property (p_timeout) else $error("ring not ended"); // R9
   property p_disabled;
      !enable_r |=> st_r == ring_val_pkg::S_IDLE && !ring_valid;
   endproperty
   a_disabled: assert property (p_disabled) else $error("runs while disabled"); // R10
   property p_reserved;
      bus.rd_addr == `RV_ADDR_CTRL3 |-> bus.rd_data[6] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set"); // R11
   property p_set_wins;
      irq_stat_r[`RV_IRQ_VALID] |=> irq_stat_r[`RV_IRQ_VALID] || $past(clr_bits[0]);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("status lost");
   c_valid: cover property ($rose(ring_valid));
   c_high: cover property (too_high);
   c_end: cover property (timed_out ##1 !ring_valid);
endmodule : ring_validation_timing
`default_nettype wire

/* File: step_tick_gen.sv */
// free-running tick: one-cycle pulse every CYCLES clocks
// assumes sys_clk and asynchronous active-low reset
`default_nettype none
module step_tick_gen #(
   parameter int CYCLES = 40000
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   output logic tick
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic tick_nxt;

   if (CYCLES < 2) begin : g_bad_cycles
      $error("step_tick_gen: CYCLES must be at least 2");
   end

   // wrap at the period end
   assign tick_nxt = (cnt_r == W'(CYCLES - 1));
   assign cnt_nxt = tick_nxt ? '0 : cnt_r + W'(1);

   // counter and registered tick
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
         tick <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick <= tick_nxt;
      end
   end

   property p_tick_spacing;
      @(posedge sys_clk) disable iff (!arst_n) tick |=> !tick;
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("tick not single"); // R4
endmodule : step_tick_gen
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for ring validation timing
// assumes short step and ms counts so that millisecond timing fits the run
`default_nettype none
`include "ring_val_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, half = 8'h00, rd, v;
   logic [31:0] wdata = 32'h0, rdata, lfsr_r = 32'h0ba8;
   // response readies stay high so back-to-back calls never re-drive them
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, ring_cross, ring_valid, irq, rc_q;
   logic [1:0] bresp, rresp, resp;
   int num_errors = 0, checks = 0, cyc = 0, last_rise = 0, t0, n, e, i, to, h;
   always #12.5 sys_clk = ~sys_clk;
   ring_validation_timing #(.STEP_CYCLES(8), .MS_CYCLES(4), .ADDR_W(8)) uut (
      .sys_clk(sys_clk), .arst_n(arst_n), .s_awaddr(awaddr), .s_awvalid(awvalid),
      .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid),
      .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
      .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
      .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .ring_cross(ring_cross),
      .ring_valid(ring_valid), .irq(irq));
   ring_line_model line (.sys_clk(sys_clk), .half(half), .ring_cross(ring_cross));
   // cycle count and time of the latest rising crossing
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      rc_q <= ring_cross;
      if (ring_cross && !rc_q) last_rise <= cyc;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   // expected confirmation time in ms per code
   function automatic int conf_ms(input int c);
      int t[8] = '{100, 150, 200, 256, 384, 512, 640, 1024};
      return t[c];
   endfunction : conf_ms
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cycles(input int k);
      repeat (k) @(posedge sys_clk);
   endtask : cycles
   // axi4-lite write: both halves offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
   endtask : wr
   task automatic rdreg(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata[7:0];
      resp = rresp;
   endtask : rdreg
   task automatic end_of_test;
      $display("checks %0d, errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   // watchdog: the tests take about 25000 cycles
   initial begin
      cycles(80000);
      num_errors++;
      $display("Error at %0t: watchdog expired", $time);
      end_of_test();
   end
   // main sequence
   initial begin
      cycles(12);
      arst_n <= 1'b1;
      cycles(1);
      rdreg(`RV_ADDR_CTRL2);
      check(rd, 8'h2d);
      rdreg(`RV_ADDR_CTRL3);
      check(rd & 8'hbf, 8'h19);
      rdreg(8'hfc);
      check(resp, `RV_RESP_SLVERR);
      lfsr_r = lfsr_next(lfsr_r);
      v = lfsr_r[7:0];
      wr(`RV_ADDR_CTRL2, v);
      check(resp, `RV_RESP_OKAY);
      wr(8'hfc, 8'h00);
      check(resp, `RV_RESP_SLVERR);
      rdreg(`RV_ADDR_CTRL2);
      check(rd, v);
      $display("test registers done");
      wr(`RV_ADDR_IRQ_EN, 8'h03);
      rdreg(`RV_ADDR_IRQ_EN);
      check(rd, 8'h03);
      wr(`RV_ADDR_CTRL3, 8'h8a);
      // every confirm code; a delay case; slow ring for a saturating timer
      for (i = 0; i < 8; i++) begin
         to = i % 4;
         wr(`RV_ADDR_SPACING, {1'b0, i == 5, 6'h05});
         wr(`RV_ADDR_CTRL2, {1'b0, to[3:0], i[2:0]});
         lfsr_r = lfsr_next(lfsr_r);
         h = (i == 6) ? 60 : 25 + lfsr_r[3:0] % 10;
         half <= h[7:0];
         do @(posedge sys_clk); while (ring_cross !== 1'b1);
         t0 = cyc;
         do @(posedge sys_clk); while (ring_valid !== 1'b1);
         e = 4 * (conf_ms(i) + (i == 5 ? 256 : 0));
         check(cyc - t0 >= e - 4 && cyc - t0 <= e + 24, 1'b1);
         rdreg(`RV_ADDR_LINE_STAT);
         check(rd, 8'h07);
         cycles(100);
         half <= 8'h00;
         do @(posedge sys_clk); while (ring_valid !== 1'b0);
         e = 4 * (to == 0 ? 80 : to * 128);
         check(cyc - last_rise >= e - 4 && cyc - last_rise <= e + 20, 1'b1);
         rdreg(`RV_ADDR_IRQ_STAT);
         check(rd, 8'h03);
         check(irq, 1'b1);
         wr(`RV_ADDR_IRQ_CLR, 8'h07);
         check(irq, 1'b0);
         $display("test ring %0d done", i);
      end
      // too-high frequency: events 16 cycles apart
      wr(`RV_ADDR_CTRL2, 8'h00);
      half <= 8'h08;
      cycles(600);
      check(ring_valid, 1'b0);
      rdreg(`RV_ADDR_IRQ_STAT);
      check(rd[2], 1'b1);
      check(irq, 1'b0);
      wr(`RV_ADDR_IRQ_EN, 8'h07);
      check(irq, 1'b1);
      half <= 8'h00;
      cycles(400);
      wr(`RV_ADDR_IRQ_CLR, 8'h07);
      cycles(2);
      check(irq, 1'b0);
      $display("test too high done");
      // validation disabled: a good ring must be ignored
      wr(`RV_ADDR_CTRL3, 8'h0a);
      half <= 8'd30;
      cycles(800);
      check(ring_valid, 1'b0);
      rdreg(`RV_ADDR_IRQ_STAT);
      check(rd, 8'h00);
      half <= 8'h00;
      $display("test disabled done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
